// ==== rtl/lsic_top.v ====
// Link sync request input control and readback pin drive
`timescale 1ns/1ps
// Contract
// - Readback pin floats except during reads and for four clocks after reset release
// - Select 0 uses single-ended sync pin
// - 64b/66b ignores sync; NCO align only
// - Low sync request starts code group sync
// - Sync release high starts lane alignment
// - Select 1 uses differential timestamp pair
module lsic_top #(
	parameter ILAS_LEN = 8
) (
	// Clock and reset
	input  wire       clk,
	input  wire       arst_n,
	// Serial readback
	input  wire       spi_read_active,
	input  wire       spi_read_data,
	output reg        sdo_out,
	output reg        sdo_oe_n,
	// Sync request sources, active low
	input  wire       sync_pin_n,
	input  wire       timestamp_diff_pair,
	// Configuration
	input  wire       sync_sel,
	input  wire       code_64b66b,
	input  wire       nco_sync_enable,
	// Link control
	output reg        send_cgs,
	output reg        send_ilas,
	output reg        send_data,
	output reg        nco_sync_pulse
);
`include "lsic_map.vh"
// ****************************************
// Input synchronisers
// ****************************************
wire pin_lvl;
wire diff_lvl;
lsic_sync3 u_sync_pin (
	.clk     (clk),
	.arst_n  (arst_n),
	.pin     (sync_pin_n),
	.level_q (pin_lvl)
);
lsic_sync3 u_sync_diff (
	.clk     (clk),
	.arst_n  (arst_n),
	.pin     (timestamp_diff_pair),
	.level_q (diff_lvl)
);
wire rd_act;
wire rd_dat;
lsic_sync3 u_sync_rd (
	.clk     (clk),
	.arst_n  (arst_n),
	.pin     (spi_read_active),
	.level_q (rd_act)
);
lsic_sync3 u_sync_rdd (
	.clk     (clk),
	.arst_n  (arst_n),
	.pin     (spi_read_data),
	.level_q (rd_dat)
);
// ****************************************
// Source selection
// ****************************************
wire req_n;
assign req_n = (sync_sel == `LSIC_SEL_DIFF) ? diff_lvl : pin_lvl;
reg  req_n_q;
// ****************************************
// Link state machine
// ****************************************
reg  [3:0] state_q;
reg  [3:0] state_d;
reg  [7:0] cnt_q;
reg  [7:0] cnt_d;
// Length kept short; ILAS multiframe count is a parameter
wire [7:0] ilas_len = ILAS_LEN[7:0];
always @* begin
	state_d = state_q;
	cnt_d   = cnt_q;
	case (state_q)
	`LSIC_ST_IDLE: begin
		if (code_64b66b == `LSIC_CODE_64B66B) begin
			state_d = `LSIC_ST_DATA;
		end else if (!req_n) begin
			state_d = `LSIC_ST_CGS;
		end
	end
	`LSIC_ST_CGS: begin
		if (code_64b66b == `LSIC_CODE_64B66B) begin
			state_d = `LSIC_ST_DATA;
		end else if (req_n) begin
			state_d = `LSIC_ST_ILAS;
			cnt_d   = `LSIC_CNT_ZERO;
		end
	end
	`LSIC_ST_ILAS: begin
		if (code_64b66b == `LSIC_CODE_64B66B) begin
			state_d = `LSIC_ST_DATA;
		end else if (!req_n) begin
			state_d = `LSIC_ST_CGS;
		end else if (cnt_q == ilas_len - `LSIC_CNT_ONE) begin
			state_d = `LSIC_ST_DATA;
		end else begin
			cnt_d = cnt_q + `LSIC_CNT_ONE;
		end
	end
	`LSIC_ST_DATA: begin
		// In 8b/10b a resync request drops sample data at once
		if ((code_64b66b == `LSIC_CODE_8B10B) && !req_n) begin
			state_d = `LSIC_ST_CGS;
		end
	end
	default: begin
		state_d = `LSIC_ST_IDLE;
	end
	endcase
end
always @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		state_q        <= `LSIC_ST_IDLE;
		cnt_q          <= `LSIC_CNT_ZERO;
		req_n_q        <= 1'b1;
		send_cgs       <= `LSIC_RST_ZERO;
		send_ilas      <= `LSIC_RST_ZERO;
		send_data      <= `LSIC_RST_ZERO;
		nco_sync_pulse <= `LSIC_RST_ZERO;
		sdo_out        <= `LSIC_RST_ZERO;
		sdo_oe_n       <= 1'b1;
	end else begin
		state_q   <= state_d;
		cnt_q     <= cnt_d;
		req_n_q   <= req_n;
		send_cgs  <= (state_d == `LSIC_ST_CGS);
		send_ilas <= (state_d == `LSIC_ST_ILAS);
		send_data <= (state_d == `LSIC_ST_DATA);
		// Falling request edge aligns NCOs in 64b/66b only
		nco_sync_pulse <= (code_64b66b == `LSIC_CODE_64B66B) && nco_sync_enable
			&& req_n_q && !req_n;
		sdo_oe_n <= !rd_act;
		sdo_out  <= rd_act ? rd_dat : `LSIC_RST_ZERO;
	end
end
endmodule // lsic_top

// ==== include/lsic_map.vh ====
// Constants for the link sync input control block
`ifndef LSIC_MAP_VH
`define LSIC_MAP_VH
// ****************************************
// Encodings
// ****************************************
`define LSIC_SEL_PIN      1'h0
`define LSIC_SEL_DIFF     1'h1
`define LSIC_CODE_8B10B   1'h0
`define LSIC_CODE_64B66B  1'h1
`define LSIC_RST_SYNC     3'h7
`define LSIC_RST_ZERO     1'h0
// ****************************************
// Link states, one-hot
// ****************************************
`define LSIC_ST_CGS       4'h1
`define LSIC_ST_ILAS      4'h2
`define LSIC_ST_DATA      4'h4
`define LSIC_ST_IDLE      4'h8
`define LSIC_ILAS_LEN     8'h04
`define LSIC_CNT_ZERO     8'h00
`define LSIC_CNT_ONE      8'h01
`endif

// ==== rtl/lsic_sync3.v ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module lsic_sync3 (
	// Clock and reset
	input  wire clk,
	input  wire arst_n,
	// Pin and result
	input  wire pin,
	output reg  level_q
);
`include "lsic_map.vh"
reg  [2:0] stage_q;
// Stage 0 is read only by stage 1
always @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		stage_q <= `LSIC_RST_SYNC;
		level_q <= 1'b1;
	end else begin
		stage_q <= {stage_q[1:0], pin};
		if (stage_q[1] == stage_q[2]) begin
			level_q <= stage_q[2];
		end
	end
end
endmodule // lsic_sync3

// ==== tb/lsic_top_asserts.sv ====
// Checker for link sync input control
`timescale 1ns/1ps
module lsic_chk (
	input wire clk, arst_n, spi_read_active, sdo_oe_n, sync_pin_n, timestamp_diff_pair,
	input wire sync_sel, code_64b66b, send_cgs, send_ilas, send_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_OE: assert property (!spi_read_active [*6] |-> sdo_oe_n) else $error("pin driven when idle");
	AST_PIN: assert property ((!sync_sel && !code_64b66b && !sync_pin_n) [*8] |-> send_cgs)
		else $error("pin request missed");
	AST_REL: assert property ((!sync_sel && !code_64b66b && sync_pin_n) [*8] |-> !send_cgs)
		else $error("sync kept after release");
	AST_DIFF: assert property ((sync_sel && !code_64b66b && !timestamp_diff_pair) [*8] |-> send_cgs)
		else $error("pair request missed");
	AST_64: assert property (code_64b66b [*8] |-> !send_cgs && !send_ilas) else $error("request used");
	AST_ILAS: assert property ($rose(send_ilas) |-> $past(send_cgs)) else $error("alignment out of order");
	AST_ONE: assert property ($onehot0({send_cgs, send_ilas, send_data})) else $error("states overlap");
	CV_ILAS: cover property ($rose(send_ilas));
	CV_64: cover property (code_64b66b && send_data);
	CV_RD: cover property ($fell(sdo_oe_n));
endmodule // lsic_chk
bind lsic_top lsic_chk u_chk (.*);

// ==== tb/lsic_rx_model.sv ====
// Receiver model driving the sync request
`timescale 1ns/1ps
module lsic_rx (
	input wire clk, arst_n, restart, send_cgs,
	input wire [3:0] lag,
	output reg sync_n
);
	reg [3:0] cnt_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_n <= 1'h1;
			cnt_q <= 4'h0;
		end else if (restart) begin
			sync_n <= 1'h0;
			cnt_q <= 4'h0;
		end else if (send_cgs && !sync_n) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q >= lag) sync_n <= 1'h1;
		end
	end
endmodule // lsic_rx

// ==== tb/tb_top.sv ====
// Testbench for link sync input control
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin num_errors++; \
	$display("wrong value %s exp %0d got %0d", n, e, s); end end
module tb_top;
	reg clk = 0, arst_n = 0, rd = 0, rdd = 0, sel = 0, m64 = 0, nco = 0, rst_rx = 0, other = 1, hold = 0;
	reg [3:0] lag = 4'h0;
	wire sdo, oe_n, cgs, ilas, dat, pulse, rq;
	integer seed = 65, num_errors = 0, checks_done = 0, i, k, n_cgs = 0, n_ilas = 0, n_pls = 0;
	always #25 clk = ~clk;
	lsic_rx u_rx (.clk(clk), .arst_n(arst_n), .restart(rst_rx), .send_cgs(cgs), .lag(lag), .sync_n(rq));
	lsic_top #(.ILAS_LEN(4)) u_dut (.clk(clk), .arst_n(arst_n), .spi_read_active(rd), .spi_read_data(rdd),
		.sdo_out(sdo), .sdo_oe_n(oe_n), .sync_pin_n(sel ? other : rq), .timestamp_diff_pair(sel ? rq : other),
		.sync_sel(sel), .code_64b66b(m64), .nco_sync_enable(nco), .send_cgs(cgs), .send_ilas(ilas),
		.send_data(dat), .nco_sync_pulse(pulse));
	// Unselected source toggles so a wrong select shows up
	// Held high before a select change: a stale random level would fake a request
	always @(posedge clk) other <= hold ? 1'h1 : $random(seed);
	always @(negedge clk) begin
		n_pls = n_pls + pulse;
		n_cgs = n_cgs + cgs;
		n_ilas = n_ilas + ilas;
	end
	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1;
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			hold <= 1;
			repeat (6) @(posedge clk);
			hold <= 0;
			sel <= i[0];
			m64 <= i[1];
			nco <= i[2];
			rd <= $random(seed);
			rdd <= $random(seed);
			lag <= $random(seed);
			rst_rx <= 1;
			@(posedge clk);
			rst_rx <= 0;
			n_cgs = 0;
			n_ilas = 0;
			n_pls = 0;
			// Settle first: a stale data state must not end the wait
			repeat (8) @(posedge clk);
			k = 0;
			while (dat !== 1'h1 && k < 60) begin
				@(posedge clk);
				k++;
			end
			@(negedge clk);
			`CHK("data", 1, dat)
			`CHK("cgs seen", !m64, n_cgs > 0)
			`CHK("ilas len", m64 ? 0 : 4, n_ilas)
			`CHK("nco pulses", (m64 && nco) ? 1 : 0, n_pls)
			`CHK("oe_n", !rd, oe_n)
			`CHK("sdo", rd & rdd, sdo)
			$display("test %0d done", i);
		end
		report_and_stop;
	end
endmodule // tb_top
